// >>> rtl/ahl_pkg.sv
`default_nettype none
package ahl_pkg;
    localparam int DEPTH = 10;
    localparam int CODE_W = 12;
    localparam int IDX_W = 4;
    // 13 years of 100 ms ticks needs about 4.1e9 counts, so 32 bits
    localparam int STAMP_W = 32;
    localparam int TICK_NS = 100000000;
    localparam int CLK_NS = 10;
    localparam int TICK_CYCLES = TICK_NS / CLK_NS;
    localparam int HOUR_MS = 3600000;
    localparam int TICK_MS = 100;
    localparam logic [STAMP_W-1:0] HOUR_TICKS = STAMP_W'(HOUR_MS / TICK_MS);
    localparam logic [CODE_W-1:0] EMPTY_CODE = 12'hfff;
endpackage : ahl_pkg
`default_nettype wire

// >>> rtl/ahl_time_base.sv
`default_nettype none
module ahl_time_base #(
    parameter int TICK_CYCLES = ahl_pkg::TICK_CYCLES
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_power_on,
    output logic [ahl_pkg::STAMP_W-1:0] o_stamp
);
    logic [31:0] div_ff;
    logic [31:0] nxt_div;
    logic [ahl_pkg::STAMP_W-1:0] stamp_ff = '0;
    logic [ahl_pkg::STAMP_W-1:0] nxt_stamp;

    always_comb begin
        nxt_div = div_ff;
        nxt_stamp = stamp_ff;
        if (i_power_on) begin
            if (div_ff == 32'(TICK_CYCLES - 1)) begin
                nxt_div = 32'h0;
                nxt_stamp = stamp_ff + 1'b1;
            end else begin
                nxt_div = div_ff + 32'h1;
            end
        end
    end

    // Reset zeroes the fraction only; total operating time is kept
    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            div_ff <= 32'h0;
        end else begin
            div_ff <= nxt_div;
        end
        stamp_ff <= nxt_stamp;
    end

    assign o_stamp = stamp_ff;
endmodule : ahl_time_base
`default_nettype wire

// >>> rtl/ahl_alarm_log.sv
`default_nettype none
module ahl_alarm_log #(
    parameter int DEPTH = ahl_pkg::DEPTH,
    parameter int TICK_CYCLES = ahl_pkg::TICK_CYCLES,
    parameter logic [ahl_pkg::STAMP_W-1:0] HOUR_TICKS = ahl_pkg::HOUR_TICKS
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_power_on,
    input wire logic i_alarm_valid,
    input wire logic [ahl_pkg::CODE_W-1:0] i_alarm_code,
    input wire logic i_alarm_reset,
    input wire logic i_op_view,
    input wire logic i_op_clear,
    input wire logic i_pc_view,
    input wire logic i_pc_clear,
    input wire logic [ahl_pkg::IDX_W-1:0] i_index,
    output logic [ahl_pkg::CODE_W-1:0] o_code,
    output logic [ahl_pkg::STAMP_W-1:0] o_stamp,
    output logic o_view_active,
    output logic o_console_conflict_indication,
    output logic [ahl_pkg::STAMP_W-1:0] o_now
);
    // Power-up contents only: no reset ever touches the log afterwards
    logic [ahl_pkg::CODE_W-1:0] code_ff [DEPTH] = '{default: ahl_pkg::EMPTY_CODE};
    logic [ahl_pkg::STAMP_W-1:0] stamp_ff [DEPTH] = '{default: '0};
    logic [ahl_pkg::CODE_W-1:0] nxt_code [DEPTH];
    logic [ahl_pkg::STAMP_W-1:0] nxt_stamp [DEPTH];
    logic [ahl_pkg::CODE_W-1:0] rd_code_ff;
    logic [ahl_pkg::STAMP_W-1:0] rd_stamp_ff;
    logic [ahl_pkg::CODE_W-1:0] nxt_rd_code;
    logic [ahl_pkg::STAMP_W-1:0] nxt_rd_stamp;
    logic view_ff;
    logic conflict_ff;
    logic nxt_view;
    logic nxt_conflict;
    logic [ahl_pkg::STAMP_W-1:0] now;
    logic op_req;
    logic pc_req;
    logic do_clear;
    logic dup_recent;
    logic do_log;

    ahl_time_base #(.TICK_CYCLES(TICK_CYCLES)) u_time (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_power_on(i_power_on),
        .o_stamp(now)
    );

    function automatic logic is_recent(input logic [ahl_pkg::STAMP_W-1:0] t_now,
                                       input logic [ahl_pkg::STAMP_W-1:0] t_then);
        is_recent = (t_now - t_then) <= HOUR_TICKS;
    endfunction : is_recent

    assign op_req = i_op_view | i_op_clear;
    assign pc_req = i_pc_view | i_pc_clear;
    assign do_clear = (i_op_clear & ~pc_req) | (i_pc_clear & ~op_req);

    // Only the latest occurrence of a code matters; newer slots sit at lower indices
    always_comb begin
        dup_recent = 1'b0;
        for (int i = DEPTH - 1; i >= 0; i--) begin
            if (code_ff[i] == i_alarm_code) begin
                dup_recent = is_recent(now, stamp_ff[i]);
            end
        end
    end

    // Clear wins over a same-cycle alarm; the alarm is assumed part of the erased history
    assign do_log = i_alarm_valid & ~dup_recent & ~do_clear & (i_alarm_code != ahl_pkg::EMPTY_CODE);

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            nxt_code[i] = code_ff[i];
            nxt_stamp[i] = stamp_ff[i];
        end
        if (do_clear) begin
            for (int i = 0; i < DEPTH; i++) begin
                nxt_code[i] = ahl_pkg::EMPTY_CODE;
                nxt_stamp[i] = '0;
            end
        end else if (do_log) begin
            for (int i = DEPTH - 1; i > 0; i--) begin
                nxt_code[i] = code_ff[i-1];
                nxt_stamp[i] = stamp_ff[i-1];
            end
            nxt_code[0] = i_alarm_code;
            nxt_stamp[0] = now;
        end
    end

    // Read path: an index past the log reads as an empty slot
    always_comb begin
        nxt_view = (i_op_view ^ i_pc_view) & ~(op_req & pc_req);
        nxt_conflict = op_req & pc_req;
        nxt_rd_code = ahl_pkg::EMPTY_CODE;
        nxt_rd_stamp = '0;
        if (int'(i_index) < DEPTH) begin
            nxt_rd_code = code_ff[i_index];
            nxt_rd_stamp = stamp_ff[i_index];
        end
    end

    // The log has no reset: it must survive alarm reset and power loss
    always_ff @(posedge i_core_clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            code_ff[i] <= nxt_code[i];
            stamp_ff[i] <= nxt_stamp[i];
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
            view_ff <= 1'b0;
            conflict_ff <= 1'b0;
            rd_code_ff <= ahl_pkg::EMPTY_CODE;
            rd_stamp_ff <= '0;
        end else begin
            view_ff <= nxt_view;
            conflict_ff <= nxt_conflict;
            rd_code_ff <= nxt_rd_code;
            rd_stamp_ff <= nxt_rd_stamp;
        end
    end

    assign o_code = rd_code_ff;
    assign o_stamp = rd_stamp_ff;
    assign o_view_active = view_ff;
    assign o_console_conflict_indication = conflict_ff;
    assign o_now = now;

    sequence s_new_alarm;
        do_log;
    endsequence

    new_entry_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_new_alarm |=> code_ff[0] == $past(i_alarm_code) && stamp_ff[0] == $past(now))
        else $error("new alarm not stored at slot 0");
    shift_down_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_new_alarm |=> code_ff[DEPTH-1] == $past(code_ff[DEPTH-2]) && code_ff[1] == $past(code_ff[0]))
        else $error("entries not shifted");
    dup_block_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_alarm_valid && code_ff[0] == i_alarm_code && now - stamp_ff[0] <= HOUR_TICKS) |-> !do_log)
        else $error("repeat within an hour logged");
    clear_empty_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        do_clear |=> code_ff[0] == ahl_pkg::EMPTY_CODE && code_ff[DEPTH-1] == ahl_pkg::EMPTY_CODE)
        else $error("clear left entries");
    keep_log_a: assert property (@(posedge i_core_clk)
        (!do_log && !do_clear) |=> code_ff[0] == $past(code_ff[0]) && stamp_ff[0] == $past(stamp_ff[0]))
        else $error("log changed without cause");
    conflict_flag_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (op_req && pc_req) |-> !do_clear ##1 o_console_conflict_indication && !o_view_active)
        else $error("conflict not refused");
    read_index_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_index == 4'h0) |=> o_code == $past(code_ff[0]))
        else $error("index 0 not newest");
    stamp_count_a: assert property (@(posedge i_core_clk)
        !i_power_on |=> now == $past(now))
        else $error("stamp ran without power");

    sequence s_late_repeat;
        i_alarm_valid && !do_clear && i_alarm_code != ahl_pkg::EMPTY_CODE
            && code_ff[0] == i_alarm_code && now - stamp_ff[0] > HOUR_TICKS;
    endsequence

    sequence s_reset_only;
        i_alarm_reset && !do_log && !do_clear;
    endsequence

    sequence s_one_viewer;
        (i_op_view ^ i_pc_view) && !(op_req && pc_req);
    endsequence

    // Slot 0 is the newest entry of its code, so an old stamp there must be taken again
    late_repeat_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_late_repeat |-> do_log)
        else $error("repeat after an hour dropped");
    alarm_reset_keep_a: assert property (@(posedge i_core_clk)
        s_reset_only |=> code_ff[DEPTH-1] == $past(code_ff[DEPTH-1])
            && stamp_ff[DEPTH-1] == $past(stamp_ff[DEPTH-1]))
        else $error("alarm reset altered the log");
    empty_code_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_alarm_valid && i_alarm_code == ahl_pkg::EMPTY_CODE) |-> !do_log)
        else $error("empty marker logged as an alarm");
    clear_stamp_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        do_clear |=> stamp_ff[0] == '0 && stamp_ff[DEPTH-1] == '0)
        else $error("clear left time stamps");

    // Console arbitration
    view_grant_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        s_one_viewer |=> o_view_active && !o_console_conflict_indication)
        else $error("single console view not granted");
    view_drop_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        !(i_op_view || i_pc_view) |=> !o_view_active)
        else $error("view shown without a request");
    conflict_keep_a: assert property (@(posedge i_core_clk)
        (op_req && pc_req && !i_alarm_valid) |=> code_ff[DEPTH-1] == $past(code_ff[DEPTH-1]))
        else $error("refused function changed the log");

    // Read port
    read_oldest_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (int'(i_index) == DEPTH - 1) |=> o_code == $past(code_ff[DEPTH-1])
            && o_stamp == $past(stamp_ff[DEPTH-1]))
        else $error("last index not oldest");
    index_empty_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
        (int'(i_index) >= DEPTH) |=> o_code == ahl_pkg::EMPTY_CODE && o_stamp == '0)
        else $error("index past the log not empty");

    // Time stamp counter
    stamp_step_a: assert property (@(posedge i_core_clk)
        i_power_on |=> now == $past(now) || now == $past(now) + 1'b1)
        else $error("stamp jumped");
    stamp_gap_a: assert property (@(posedge i_core_clk)
        (TICK_CYCLES > 1 && $changed(now)) |=> !$changed(now))
        else $error("stamp moved twice in a row");
    stamp_nowrap_a: assert property (@(posedge i_core_clk)
        now != '0 |=> now != '0)
        else $error("stamp wrapped");
endmodule : ahl_alarm_log
`default_nettype wire

// >>> verif/ahl_console_model.sv
`default_nettype none
module ahl_console_model (
    input wire logic i_core_clk,
    input wire logic [1:0] i_want_view,
    input wire logic [1:0] i_want_clear,
    output logic o_op_view,
    output logic o_pc_view,
    output logic o_op_clear,
    output logic o_pc_clear
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] held_ff = 2'h0;
    // A held clear key issues one request only, as a console runs a function once per press
    always @(posedge i_core_clk) held_ff <= i_want_clear;
    assign o_op_view = i_want_view[0];
    assign o_pc_view = i_want_view[1];
    assign o_op_clear = i_want_clear[0] & ~held_ff[0];
    assign o_pc_clear = i_want_clear[1] & ~held_ff[1];
endmodule : ahl_console_model
`default_nettype wire

// >>> verif/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TICKS = 4;
    localparam int HOUR = 5;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic pwr = 1'b1;
    logic av = 1'b0;
    logic ar = 1'b0;
    logic [11:0] ac = 12'h0;
    logic [1:0] wv = 2'h0;
    logic [1:0] wc = 2'h0;
    logic [3:0] idx = 4'h0;
    logic opv, pcv, opc, pcc, va, cf;
    logic [11:0] code;
    logic [31:0] stamp, now;
    logic [31:0] rs = 32'hf41d;
    int fails = 0;
    int comparisons = 0;
    int cyc = 0;
    int div = 0;
    int mnow = 0;
    int qc[$];
    int qs[$];
    ahl_console_model con (.i_core_clk(clk), .i_want_view(wv), .i_want_clear(wc), .o_op_view(opv),
        .o_pc_view(pcv), .o_op_clear(opc), .o_pc_clear(pcc));
    ahl_alarm_log #(.TICK_CYCLES(TICKS), .HOUR_TICKS(32'(HOUR))) dut (.i_core_clk(clk), .i_rst(rst),
        .i_power_on(pwr), .i_alarm_valid(av), .i_alarm_code(ac), .i_alarm_reset(ar), .i_op_view(opv),
        .i_op_clear(opc), .i_pc_view(pcv), .i_pc_clear(pcc), .i_index(idx), .o_code(code),
        .o_stamp(stamp), .o_view_active(va), .o_console_conflict_indication(cf), .o_now(now));
    always #5 clk = ~clk;
    task automatic summarize();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : summarize
    // Powered time in ticks, kept apart from the design's counter
    always @(posedge clk) begin
        cyc++;
        div = rst ? 0 : div + int'(pwr);
        if (div == TICKS) begin
            div = 0;
            mnow++;
        end
        if (cyc == 2000) begin
            fails++;
            summarize();
        end
    end
    task automatic step();
        @(posedge clk);
        #1;
    endtask : step
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    function automatic logic [11:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return (rs[11:0] == 12'hfff) ? 12'h0 : rs[11:0];
    endfunction : rnd
    // Leaves the strobe up so back-to-back calls never lower and raise it in one step
    task automatic alarm(logic [11:0] c);
        int k;
        k = -1;
        foreach (qc[i]) if (k < 0 && qc[i] == c) k = i;
        av = 1'b1;
        ac = c;
        if (c != 12'hfff && (k < 0 || mnow - qs[k] > HOUR)) begin
            qc.push_front(c);
            qs.push_front(mnow);
        end
        if (qc.size() > 10) begin
            void'(qc.pop_back());
            void'(qs.pop_back());
        end
        step();
    endtask : alarm
    task automatic rd_all();
        for (int i = 0; i < 16; i++) begin
            idx = 4'(i);
            step();
            chk("code", (i < qc.size()) ? qc[i] : 'hfff, code);
            chk("stamp", (i < qs.size()) ? qs[i] : 0, stamp);
        end
    endtask : rd_all
    initial begin
        repeat (16) step();
        rst = 1'b0;
        rd_all();
        repeat (12) alarm(rnd());
        alarm(12'hfff);
        alarm(12'(qc[0]));
        av = 1'b0;
        rd_all();
        repeat (12) step();
        alarm(12'(qc[0]));
        repeat (30) alarm(12'(qc[0]));
        av = 1'b0;
        ar = 1'b1;
        step();
        ar = 1'b0;
        pwr = 1'b0;
        repeat (40) step();
        chk("now", mnow, now);
        rst = 1'b1;
        step();
        rst = 1'b0;
        pwr = 1'b1;
        rd_all();
        wv = 2'h3;
        step();
        chk("conflict", 1, {31'h0, cf});
        chk("view", 0, {31'h0, va});
        wv = 2'h1;
        step();
        chk("view", 1, {31'h0, va});
        wv = 2'h2;
        step();
        chk("view", 1, {31'h0, va});
        wv = 2'h0;
        wc = 2'h3;
        step();
        wc = 2'h0;
        rd_all();
        wc = 2'h2;
        alarm(12'h5a5);
        wc = 2'h0;
        av = 1'b0;
        qc.delete();
        qs.delete();
        rd_all();
        alarm(12'h3c3);
        av = 1'b0;
        wc = 2'h1;
        qc.delete();
        qs.delete();
        step();
        wc = 2'h0;
        rd_all();
        summarize();
    end
endmodule : testbench
`default_nettype wire
